/* src/dcr_line_filter.sv */
// synchroniser and programmable bounce filter for one front line
`timescale 1ns/1ps
module dcr_line_filter
  import dcr_pkg::*;
#(
  parameter int DEB_W = DCR_DEB_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // pin and filter setting
  input wire logic pin_i,
  input wire logic [DEB_W-1:0] deb_i,
  // conditioned level
  dcr_lvl_if.src lvl
);

  localparam int CW = DEB_W + 2;

  typedef struct packed {
    logic [DCR_SYNC_W-1:0] stage;
    logic lvl;
    logic filt;
    logic [CW-1:0] cnt;
  } dcr_filt_s;

  dcr_filt_s s_ff;
  dcr_filt_s nxt_s;
  logic [CW-1:0] need;

  // stable cycles needed: (setting + 1) reject steps; a level passes only
  // once it has held one cycle beyond that, since an unaligned pulse just
  // shorter than the reject time can still straddle that many edges
  assign need = CW'((32'(deb_i) + 1) * DCR_REJECT_STEP_CYC);

  // sync, then pass a level only after it held long enough
  always_comb begin
    nxt_s = s_ff;
    nxt_s.stage = {s_ff.stage[DCR_SYNC_W-2:0], pin_i};
    if (s_ff.stage[1] == s_ff.stage[2]) begin
      nxt_s.lvl = s_ff.stage[2];
    end
    if (s_ff.lvl == s_ff.filt) begin
      nxt_s.cnt = '0;
    end else if (CW'(s_ff.cnt + 1'b1) > need) begin
      nxt_s.filt = s_ff.lvl;
      nxt_s.cnt = '0;
    end else begin
      nxt_s.cnt = CW'(s_ff.cnt + 1'b1);
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lvl.sync = s_ff.lvl;
  assign lvl.filt = s_ff.filt;

endmodule

/* src/dcr_lvl_if.sv */
// level carrier from a pin conditioner to the routing logic
`timescale 1ns/1ps
interface dcr_lvl_if;
  logic sync;
  logic filt;
  modport src (output sync, output filt);
  modport dst (input sync, input filt);
endinterface

/* src/dcr_pin_sync.sv */
// three-stage synchroniser for a back-plane conversion line
`timescale 1ns/1ps
module dcr_pin_sync
  import dcr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // pin and conditioned level
  input wire logic pin_i,
  dcr_lvl_if.src lvl
);

  typedef struct packed {
    logic [DCR_SYNC_W-1:0] stage;
    logic lvl;
  } dcr_sync_s;

  dcr_sync_s s_ff;
  dcr_sync_s nxt_s;

  // shift in; accept a change once stages two and three agree
  always_comb begin
    nxt_s = s_ff;
    nxt_s.stage = {s_ff.stage[DCR_SYNC_W-2:0], pin_i};
    if (s_ff.stage[1] == s_ff.stage[2]) begin
      nxt_s.lvl = s_ff.stage[2];
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lvl.sync = s_ff.lvl;
  assign lvl.filt = s_ff.lvl;

endmodule

/* src/dcr_pkg.sv */
// constants and types shared by the dio and conversion routing block
package dcr_pkg;

  // ************************************************************
  // widths and counts
  // ************************************************************
  localparam int DCR_AW = 12;
  localparam int DCR_DW = 32;
  localparam int DCR_LINES = 8;
  localparam int DCR_NSIG = 3;
  localparam int DCR_FLD_W = 2;
  localparam int DCR_DEB_W = 16;
  localparam int DCR_TMR_LIM_W = 28;
  localparam int DCR_SYNC_W = 3;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [DCR_AW-1:0] DCR_OFS_OUT_ROUTE = 12'h340;
  localparam logic [DCR_AW-1:0] DCR_OFS_SRC_SEL = 12'h344;
  localparam logic [DCR_AW-1:0] DCR_OFS_TIMER = 12'h348;
  localparam logic [DCR_AW-1:0] DCR_OFS_IN_LVL = 12'h354;
  localparam logic [DCR_AW-1:0] DCR_OFS_FILTER = 12'h358;
  localparam logic [DCR_AW-1:0] DCR_OFS_OUT_LVL = 12'h35C;
  localparam logic [DCR_AW-1:0] DCR_OFS_TX_EN = 12'h360;

  // ************************************************************
  // field positions and codes
  // ************************************************************
  // conversion signal index: clock 1, clock 2, frame trigger
  localparam int DCR_SIG_CK1 = 0;
  localparam int DCR_SIG_CK2 = 1;
  localparam int DCR_SIG_FRM = 2;
  // front line carrying each conversion signal (lines 1, 3, 5)
  localparam int DCR_FRONT_LINE [DCR_NSIG] = '{0, 2, 4};
  // source and driver field codes; msb clear means generator source, or no drive
  localparam int DCR_SRC_EXT_BIT = 1;
  localparam logic [DCR_FLD_W-1:0] DCR_SRC_GLOBAL = 2'h2;
  localparam logic [DCR_FLD_W-1:0] DCR_SRC_FRONT = 2'h3;
  localparam int DCR_ROUTE_W = DCR_FLD_W * DCR_NSIG;
  // frame interval register bits
  localparam int DCR_TMR_EN_BIT = 31;
  localparam int DCR_TMR_SEL_BIT = 30;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [DCR_TMR_LIM_W-1:0] DCR_TMR_LIM_RST = 28'hFFFFFFF;
  localparam logic [DCR_ROUTE_W-1:0] DCR_ROUTE_RST = 6'h00;
  localparam logic [DCR_DEB_W-1:0] DCR_DEB_RST = 16'h0000;
  localparam logic [DCR_LINES-1:0] DCR_LINE_RST = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int DCR_CLK_PERIOD_NS = 50;
  localparam int DCR_REJECT_STEP_NS = 50;
  // least time, rounded up, never below one cycle
  localparam int DCR_REJECT_STEP_CYC =
    ((DCR_REJECT_STEP_NS + DCR_CLK_PERIOD_NS - 1) / DCR_CLK_PERIOD_NS) < 1
    ? 1
    : ((DCR_REJECT_STEP_NS + DCR_CLK_PERIOD_NS - 1) / DCR_CLK_PERIOD_NS);

  // ************************************************************
  // frame interval counter states
  // ************************************************************
  typedef enum logic {
    DCR_TMR_IDLE = 1'b0,
    DCR_TMR_RUN = 1'b1
  } dcr_tmr_e;

endpackage

/* src/dcr_routing_top.sv */
// dio port, conversion signal routing and frame interval counter
`timescale 1ns/1ps

// Functional notes
// - generator drives front pin if routed, oe clear
// - set output enable drives output register value
// - source fields: 0x gen, 10 global, 11 front
// - front sources: clock1 line1, clock2 line3, frame line5
// - enabled counter restarts on every frame trigger
// - counter clock: bit30 clear clock1, set clock2
// - expiry status set, cleared by each frame trigger
// - expires after limit plus one clocks; limit resets ones
// - input register shows every line level always
// - pulses shorter than (setting+1)*50ns are rejected
// - level passes after (setting+1) stable steps plus one cycle
// - output bit sets pin level only when enabled
// - eight transmitter enables, all cleared at reset
// - expiry raises interrupt request when enabled
module dcr_routing_top
  import dcr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [DCR_AW-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DCR_DW-1:0] reg_wdata_i,
  output logic [DCR_DW-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // on-board generators: clock 1, clock 2, frame trigger
  input wire logic [DCR_NSIG-1:0] gen_i,
  // back-plane global conversion lines
  input wire logic [DCR_NSIG-1:0] glb_i,
  output logic [DCR_NSIG-1:0] glb_o,
  output logic [DCR_NSIG-1:0] glb_oe_o,
  // front digital lines
  input wire logic [DCR_LINES-1:0] dio_i,
  output logic [DCR_LINES-1:0] dio_o,
  output logic [DCR_LINES-1:0] dio_oe_o,
  // routed conversion signals to the converters
  output logic [DCR_NSIG-1:0] conv_o,
  // frame interval interrupt
  input wire logic timer_irq_enable_i,
  output logic timer_irq_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [DCR_ROUTE_W-1:0] out_route;
    logic [DCR_ROUTE_W-1:0] src_sel;
    logic tmr_en;
    logic tmr_sel;
    logic tmr_stat;
    logic [DCR_TMR_LIM_W-1:0] tmr_lim;
    dcr_tmr_e tmr_state;
    logic [DCR_TMR_LIM_W-1:0] tmr_cnt;
    logic [DCR_DEB_W-1:0] deb;
    logic [DCR_LINES-1:0] out_lvl;
    logic [DCR_LINES-1:0] tx_en;
    logic [DCR_NSIG-1:0] conv;
    logic [DCR_NSIG-1:0] conv_prev;
    logic [DCR_LINES-1:0] dio;
    logic [DCR_LINES-1:0] dio_oe;
    logic [DCR_NSIG-1:0] glb;
    logic [DCR_NSIG-1:0] glb_oe;
    logic [DCR_DW-1:0] rdata;
    logic rvalid;
    logic irq;
  } dcr_top_s;

  dcr_top_s s_ff;
  dcr_top_s nxt_s;

  // ************************************************************
  // pin conditioning
  // ************************************************************
  logic [DCR_LINES-1:0] front_lvl;
  logic [DCR_NSIG-1:0] glb_lvl;

  dcr_lvl_if line_lvl [DCR_LINES] ();
  dcr_lvl_if back_lvl [DCR_NSIG] ();

  // front lines: synchronise and debounce each one
  for (genvar gi = 0; gi < DCR_LINES; gi++) begin : g_front
    dcr_line_filter #(
      .DEB_W(DCR_DEB_W)
    ) u_filter (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(dio_i[gi]),
      .deb_i(s_ff.deb),
      .lvl(line_lvl[gi])
    );
    assign front_lvl[gi] = line_lvl[gi].filt;
  end

  // back-plane lines: synchronise only
  for (genvar gk = 0; gk < DCR_NSIG; gk++) begin : g_back
    dcr_pin_sync u_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(glb_i[gk]),
      .lvl(back_lvl[gk])
    );
    assign glb_lvl[gk] = back_lvl[gk].sync;
  end

  // ************************************************************
  // register map
  // ************************************************************
  // 0x340 generator drive route: frame 5:4, clock 2 3:2, clock 1 1:0
  //       (0x off, 10 back-plane line, 11 front line 1, 3 or 5)
  // 0x344 source select, same layout (0x generator, 10 back-plane,
  //       11 front line)
  // 0x348 timer: enable 31, clock select 30, expiry 29 (read only),
  //       limit 27:0
  // 0x354 filtered levels of all eight lines, read only
  // 0x358 bounce filter setting 15:0
  // 0x35C line drive values 7:0
  // 0x360 line transmitter enables 7:0
  // reads answer one cycle later; unmapped reads return zero, and
  // writes to read-only or unmapped offsets are dropped

  // ************************************************************
  // timing notes
  // ************************************************************
  // external conversion signals reach the timer several cycles late;
  // the synchroniser needs two equal samples, so an external clock
  // must stay high and low for two cycles or its edge is lost
  // a frame trigger and a counter tick in one cycle: the trigger wins
  // and the count restarts from zero
  // after expiry the counter idles until the next frame trigger
  // switching a source field can look like an edge of its own, so
  // sources are best changed while the frame timer is disabled
  // generators that idle high give one edge right after reset; it is
  // harmless because the timer comes out of reset disabled

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [DCR_FLD_W-1:0] fld;
    logic [DCR_FLD_W-1:0] drv;
    logic frame_evt;
    logic tick;
    int ln;
    fld = '0;
    drv = '0;
    frame_evt = 1'b0;
    tick = 1'b0;
    ln = 0;
    nxt_s = s_ff;
    nxt_s.rvalid = 1'b0;
    nxt_s.irq = 1'b0;

    // source selection per conversion signal
    for (int k = 0; k < DCR_NSIG; k++) begin
      fld = s_ff.src_sel[DCR_FLD_W*k +: DCR_FLD_W];
      if (!fld[DCR_SRC_EXT_BIT]) begin
        nxt_s.conv[k] = gen_i[k];
      end else if (fld == DCR_SRC_GLOBAL) begin
        nxt_s.conv[k] = glb_lvl[k];
      end else begin
        nxt_s.conv[k] = front_lvl[DCR_FRONT_LINE[k]];
      end
    end
    nxt_s.conv_prev = s_ff.conv;

    // front drivers: transmitter enable takes the pin first
    // only lines 1, 3 and 5 can be lent to a generator; all others
    // are driven through their transmitter enable alone
    nxt_s.dio = s_ff.out_lvl;
    nxt_s.dio_oe = s_ff.tx_en;
    for (int k = 0; k < DCR_NSIG; k++) begin
      drv = s_ff.out_route[DCR_FLD_W*k +: DCR_FLD_W];
      ln = DCR_FRONT_LINE[k];
      if (!s_ff.tx_en[ln] && drv == DCR_SRC_FRONT) begin
        nxt_s.dio[ln] = gen_i[k];
        nxt_s.dio_oe[ln] = 1'b1;
      end
      // back-plane driver follows its own route field
      nxt_s.glb[k] = gen_i[k];
      nxt_s.glb_oe[k] = (drv == DCR_SRC_GLOBAL);
    end

    // frame trigger and counter clock edges
    frame_evt = s_ff.conv[DCR_SIG_FRM] & ~s_ff.conv_prev[DCR_SIG_FRM];
    if (s_ff.tmr_sel) begin
      tick = s_ff.conv[DCR_SIG_CK2] & ~s_ff.conv_prev[DCR_SIG_CK2];
    end else begin
      tick = s_ff.conv[DCR_SIG_CK1] & ~s_ff.conv_prev[DCR_SIG_CK1];
    end

    // every frame trigger clears the expiry status
    if (frame_evt) begin
      nxt_s.tmr_stat = 1'b0;
    end

    // frame interval counter
    unique case (s_ff.tmr_state)
      DCR_TMR_IDLE: begin
        if (s_ff.tmr_en && frame_evt) begin
          nxt_s.tmr_state = DCR_TMR_RUN;
          nxt_s.tmr_cnt = '0;
        end
      end
      DCR_TMR_RUN: begin
        if (!s_ff.tmr_en) begin
          nxt_s.tmr_state = DCR_TMR_IDLE;
        end else if (frame_evt) begin
          nxt_s.tmr_cnt = '0;
        end else if (tick) begin
          if (s_ff.tmr_cnt == s_ff.tmr_lim) begin
            nxt_s.tmr_state = DCR_TMR_IDLE;
            nxt_s.tmr_stat = 1'b1;
            nxt_s.irq = timer_irq_enable_i;
          end else begin
            nxt_s.tmr_cnt = s_ff.tmr_cnt + 1'b1;
          end
        end
      end
    endcase

    // register writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        DCR_OFS_OUT_ROUTE: begin
          nxt_s.out_route = reg_wdata_i[DCR_ROUTE_W-1:0];
        end
        DCR_OFS_SRC_SEL: begin
          nxt_s.src_sel = reg_wdata_i[DCR_ROUTE_W-1:0];
        end
        DCR_OFS_TIMER: begin
          nxt_s.tmr_en = reg_wdata_i[DCR_TMR_EN_BIT];
          nxt_s.tmr_sel = reg_wdata_i[DCR_TMR_SEL_BIT];
          nxt_s.tmr_lim = reg_wdata_i[DCR_TMR_LIM_W-1:0];
        end
        DCR_OFS_FILTER: begin
          nxt_s.deb = reg_wdata_i[DCR_DEB_W-1:0];
        end
        DCR_OFS_OUT_LVL: begin
          nxt_s.out_lvl = reg_wdata_i[DCR_LINES-1:0];
        end
        DCR_OFS_TX_EN: begin
          nxt_s.tx_en = reg_wdata_i[DCR_LINES-1:0];
        end
        default: begin
          // unmapped or read-only: write ignored
        end
      endcase
    end

    // register reads, answered one cycle later
    if (reg_rd_i) begin
      nxt_s.rvalid = 1'b1;
      unique case (reg_addr_i)
        DCR_OFS_OUT_ROUTE: nxt_s.rdata = DCR_DW'(s_ff.out_route);
        DCR_OFS_SRC_SEL: nxt_s.rdata = DCR_DW'(s_ff.src_sel);
        DCR_OFS_TIMER: begin
          nxt_s.rdata = {s_ff.tmr_en, s_ff.tmr_sel, s_ff.tmr_stat,
                         1'b0, s_ff.tmr_lim};
        end
        DCR_OFS_IN_LVL: nxt_s.rdata = DCR_DW'(front_lvl);
        DCR_OFS_FILTER: nxt_s.rdata = DCR_DW'(s_ff.deb);
        DCR_OFS_OUT_LVL: nxt_s.rdata = DCR_DW'(s_ff.out_lvl);
        DCR_OFS_TX_EN: nxt_s.rdata = DCR_DW'(s_ff.tx_en);
        default: nxt_s.rdata = '0;
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_ff <= '0;
      // limit to all ones, every other field to zero
      s_ff.out_route <= DCR_ROUTE_RST;
      s_ff.src_sel <= DCR_ROUTE_RST;
      s_ff.tmr_lim <= DCR_TMR_LIM_RST;
      s_ff.tmr_state <= DCR_TMR_IDLE;
      s_ff.deb <= DCR_DEB_RST;
      s_ff.out_lvl <= DCR_LINE_RST;
      s_ff.tx_en <= DCR_LINE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ************************************************************
  // outputs, all straight from the state register
  // ************************************************************
  assign reg_rdata_o = s_ff.rdata;
  assign reg_rvalid_o = s_ff.rvalid;
  assign glb_o = s_ff.glb;
  assign glb_oe_o = s_ff.glb_oe;
  assign dio_o = s_ff.dio;
  assign dio_oe_o = s_ff.dio_oe;
  assign conv_o = s_ff.conv;
  assign timer_irq_o = s_ff.irq;

endmodule

/* tb/dcr_far_side.sv */
// far-side model: outside ttl drivers and other boards
`timescale 1ns/1ps
module dcr_far_side
  import dcr_pkg::*;
(
  // levels the outside world puts on the lines
  input wire logic [DCR_LINES-1:0] ext_dio_i,
  input wire logic [DCR_NSIG-1:0] ext_glb_i,
  // device drivers
  input wire logic [DCR_LINES-1:0] dev_dio_i,
  input wire logic [DCR_LINES-1:0] dev_dio_oe_i,
  input wire logic [DCR_NSIG-1:0] dev_glb_i,
  input wire logic [DCR_NSIG-1:0] dev_glb_oe_i,
  // resolved wire levels
  output logic [DCR_LINES-1:0] pin_dio_o,
  output logic [DCR_NSIG-1:0] pin_glb_o
);
  // outside drivers back off wherever the device drives
  assign pin_dio_o = (dev_dio_oe_i & dev_dio_i) | (~dev_dio_oe_i & ext_dio_i);
  assign pin_glb_o = (dev_glb_oe_i & dev_glb_i) | (~dev_glb_oe_i & ext_glb_i);
endmodule

/* tb/dcr_routing_props.sv */
// port assertions for the dio and conversion routing block
`timescale 1ns/1ps
module dcr_routing_props
  import dcr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [DCR_AW-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DCR_DW-1:0] reg_wdata_i,
  input wire logic [DCR_DW-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // conversion signals and front drivers
  input wire logic [DCR_NSIG-1:0] gen_i,
  input wire logic [DCR_NSIG-1:0] conv_o,
  input wire logic [DCR_LINES-1:0] dio_o,
  input wire logic [DCR_LINES-1:0] dio_oe_o,
  // interrupt
  input wire logic timer_irq_enable_i,
  input wire logic timer_irq_o
);
  logic [5:0] sh_rt;
  logic [5:0] sh_src;
  logic [7:0] sh_tx;
  logic [7:0] sh_out;
  logic sh_ten;

  // shadow of the route, source, timer enable and line fields, updated like the device's own
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      {sh_rt, sh_src, sh_tx, sh_out, sh_ten} <= '0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        DCR_OFS_OUT_ROUTE: sh_rt <= reg_wdata_i[5:0];
        DCR_OFS_SRC_SEL: sh_src <= reg_wdata_i[5:0];
        DCR_OFS_TIMER: sh_ten <= reg_wdata_i[31];
        DCR_OFS_OUT_LVL: sh_out <= reg_wdata_i[7:0];
        DCR_OFS_TX_EN: sh_tx <= reg_wdata_i[7:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_in_rd;
    reg_rd_i && reg_addr_i == DCR_OFS_IN_LVL |=>
      reg_rvalid_o && reg_rdata_o[31:8] == 24'h000000;
  endproperty
  a_in_rd: assert property (p_in_rd) else $error("input read");
  property p_src_rb;
    reg_rd_i && reg_addr_i == DCR_OFS_SRC_SEL |=>
      reg_rdata_o == {26'h0000000, $past(sh_src)};
  endproperty
  a_src_rb: assert property (p_src_rb) else $error("source read");
  property p_gen_src;
    !sh_src[1] && !sh_src[5] |=>
      conv_o[0] == $past(gen_i[0]) && conv_o[2] == $past(gen_i[2]);
  endproperty
  a_gen_src: assert property (p_gen_src) else $error("gen source");
  property p_oe_win;
    reset_n_i |=> (dio_oe_o & $past(sh_tx)) == $past(sh_tx) &&
      ((dio_o ^ $past(sh_out)) & $past(sh_tx)) == 8'h00;
  endproperty
  a_oe_win: assert property (p_oe_win) else $error("oe override");
  property p_plain_oe;
    reset_n_i |=> {dio_oe_o[7:5], dio_oe_o[3], dio_oe_o[1]} ==
      $past({sh_tx[7:5], sh_tx[3], sh_tx[1]});
  endproperty
  a_plain_oe: assert property (p_plain_oe) else $error("plain oe");
  property p_gen_drv;
    sh_rt[1:0] == 2'h3 && !sh_tx[0] |=>
      dio_oe_o[0] && dio_o[0] == $past(gen_i[0]);
  endproperty
  a_gen_drv: assert property (p_gen_drv) else $error("gen drive");
  property p_no_drv;
    sh_rt[1:0] != 2'h3 && !sh_tx[0] |=> !dio_oe_o[0];
  endproperty
  a_no_drv: assert property (p_no_drv) else $error("stray drive");
  property p_irq_en;
    !timer_irq_enable_i ##1 !timer_irq_enable_i |-> !timer_irq_o;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("masked irq");
  property p_tmr_off;
    !sh_ten [*3] |-> !timer_irq_o;
  endproperty
  a_tmr_off: assert property (p_tmr_off) else $error("idle timer");
  property p_rst_oe;
    $rose(reset_n_i) |-> dio_oe_o == 8'h00;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("reset oe");
endmodule

bind dcr_routing_top dcr_routing_props chk_u (.*);

/* tb/tb.sv */
// self-checking bench for the dio and conversion routing block
`timescale 1ns/1ps
module tb
  import dcr_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [DCR_AW-1:0] reg_addr_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [DCR_DW-1:0] reg_wdata_i = '0;
  logic [DCR_DW-1:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic [DCR_NSIG-1:0] gen_i = '0;
  logic [DCR_NSIG-1:0] ext_glb = '0;
  logic [DCR_NSIG-1:0] glb_i, glb_o, glb_oe_o, conv_o;
  logic [DCR_LINES-1:0] ext_dio = '0;
  logic [DCR_LINES-1:0] dio_i, dio_o, dio_oe_o;
  logic timer_irq_enable_i = 1'b0;
  logic timer_irq_o;
  int errors = 0;
  int tests_run = 0;
  int irqs = 0;
  int hi = 0;
  int hi0 = 0;

  always #25 clk_i = ~clk_i;

  dcr_routing_top dut_u (.*);
  dcr_far_side far_u (
    .ext_dio_i(ext_dio),
    .ext_glb_i(ext_glb),
    .dev_dio_i(dio_o),
    .dev_dio_oe_i(dio_oe_o),
    .dev_glb_i(glb_o),
    .dev_glb_oe_i(glb_oe_o),
    .pin_dio_o(dio_i),
    .pin_glb_o(glb_i)
  );

  // count irq pulses and high cycles of routed clock 1, mid-cycle
  always @(negedge clk_i) begin
    if (timer_irq_o === 1'b1) irqs++;
    if (conv_o[0] === 1'b1) hi++;
  end

  // ************
  // bench tasks
  // ************
  task automatic finish_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [DCR_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [DCR_AW-1:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({31'h00000000, reg_rvalid_o}, 32'h00000001);
    chk(reg_rdata_o, e);
  endtask
  // n generator pulses, three cycles high and three low
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i) gen_i[k] <= 1'b1;
      cyc(2);
      @(posedge clk_i) gen_i[k] <= 1'b0;
      cyc(2);
    end
  endtask
  // one front line 1 pulse of n+1 cycles, then settle
  task automatic dpulse(input int n);
    @(posedge clk_i) ext_dio <= 8'h01;
    cyc(n);
    @(posedge clk_i) ext_dio <= 8'h00;
    cyc(15);
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #1000000;
    errors++;
    finish_test();
  end

  // ************
  // test sequence
  // ************
  initial begin
    cyc(4);
    @(posedge clk_i) reset_n_i <= 1'b1;
    rd(DCR_OFS_SRC_SEL, 32'h00000000);
    rd(DCR_OFS_TIMER, 32'h0FFFFFFF);
    rd(DCR_OFS_TX_EN, 32'h00000000);
    rd(DCR_OFS_OUT_LVL, 32'h00000000);
    rd(DCR_OFS_FILTER, 32'h00000000);
    rd(12'h400, 32'h00000000);
    wr(DCR_OFS_SRC_SEL, 32'hFFFFFFFF);
    rd(DCR_OFS_SRC_SEL, 32'h0000003F);
    wr(DCR_OFS_TIMER, 32'hFFFFFFFF);
    rd(DCR_OFS_TIMER, 32'hCFFFFFFF);
    wr(DCR_OFS_TIMER, 32'h00000000);
    // inputs, outputs and front sources
    @(posedge clk_i) ext_dio <= 8'h3C;
    wr(DCR_OFS_OUT_LVL, 32'h000000A5);
    cyc(12);
    chk({dio_oe_o, conv_o}, 11'h006);
    wr(DCR_OFS_IN_LVL, 32'h000000FF);
    rd(DCR_OFS_IN_LVL, 32'h0000003C);
    wr(DCR_OFS_TX_EN, 32'h000000FF);
    cyc(12);
    chk({dio_oe_o, dio_o, conv_o}, 19'h7FD2B);
    rd(DCR_OFS_IN_LVL, 32'h000000A5);
    // generator drive on front and back-plane
    wr(DCR_OFS_TX_EN, 32'h00000000);
    wr(DCR_OFS_OUT_ROUTE, 32'h0000003F);
    @(posedge clk_i) gen_i <= 3'h2;
    cyc(3);
    chk({dio_oe_o, dio_o[4], dio_o[2], dio_o[0]}, 11'h0AA);
    wr(DCR_OFS_TX_EN, 32'h00000001);
    cyc(2);
    chk({dio_oe_o[0], dio_o[0]}, 2'h3);
    wr(DCR_OFS_OUT_ROUTE, 32'h0000002A);
    wr(DCR_OFS_TX_EN, 32'h00000000);
    cyc(2);
    chk({glb_oe_o, glb_o, dio_oe_o}, 14'h3A00);
    wr(DCR_OFS_OUT_ROUTE, 32'h00000000);
    wr(DCR_OFS_SRC_SEL, 32'h0000002A);
    @(posedge clk_i) ext_glb <= 3'h5;
    cyc(8);
    chk(conv_o, 3'h5);
    wr(DCR_OFS_SRC_SEL, 32'h00000000);
    cyc(2);
    chk(conv_o, 3'h2);
    // bounce filter: short pulse dropped, long one passed
    wr(DCR_OFS_FILTER, 32'h00000003);
    wr(DCR_OFS_SRC_SEL, 32'h0000003F);
    @(posedge clk_i) ext_dio <= 8'h00;
    cyc(12);
    hi0 = hi;
    dpulse(2);
    chk(hi - hi0, 0);
    dpulse(7);
    chk(hi > hi0, 1);
    // frame interval counter
    wr(DCR_OFS_SRC_SEL, 32'h00000000);
    @(posedge clk_i) gen_i <= 3'h0;
    timer_irq_enable_i <= 1'b1;
    wr(DCR_OFS_TIMER, 32'h80000002);
    pulse(2, 1);
    pulse(0, 2);
    rd(DCR_OFS_TIMER, 32'h80000002);
    pulse(0, 1);
    rd(DCR_OFS_TIMER, 32'hA0000002);
    chk(irqs, 1);
    wr(DCR_OFS_TIMER, 32'hC0000000);
    pulse(2, 1);
    pulse(0, 1);
    rd(DCR_OFS_TIMER, 32'hC0000000);
    pulse(1, 1);
    rd(DCR_OFS_TIMER, 32'hE0000000);
    wr(DCR_OFS_TIMER, 32'h80000002);
    pulse(2, 1);
    pulse(0, 2);
    pulse(2, 1);
    pulse(0, 2);
    rd(DCR_OFS_TIMER, 32'h80000002);
    pulse(0, 1);
    rd(DCR_OFS_TIMER, 32'hA0000002);
    wr(DCR_OFS_TIMER, 32'h00000000);
    pulse(2, 1);
    rd(DCR_OFS_TIMER, 32'h00000000);
    pulse(0, 2);
    rd(DCR_OFS_TIMER, 32'h00000000);
    chk(irqs, 3);
    // expiry with the interrupt enable low: status only, no pulse
    @(posedge clk_i) timer_irq_enable_i <= 1'b0;
    wr(DCR_OFS_TIMER, 32'h80000000);
    pulse(2, 1);
    pulse(0, 1);
    rd(DCR_OFS_TIMER, 32'hA0000000);
    chk(irqs, 3);
    finish_test();
  end
endmodule
